// ### core/cpu_status_and_power_modes.sv
// Purpose: power-mode sequencing, power control register, status word access
// Assumes: core reaches registers through its internal special-register port
// Notes:   the core pipeline itself lives outside; this block gates it
// Behaviour
// - idle halts execution, clocks and peripherals run
// - stop halts core, oscillator, digital peripherals
// - idle bit set enters idle after instruction
// - idle keeps registers and memory intact
// - idle ends on enabled interrupt or reset
// - interrupt wake clears idle bit, services interrupt
// - return continues after idle-setting instruction
// - reset wake restarts fetch at address zero
// - watchdog timeout resets and ends idle
// - stop bit set enters stop after instruction
// - stop ends only by reset
// - lost-clock monitor resets stop after timeout
// - status bits four, three select bank
// - reset loads stack pointer with seven
`timescale 1ns/1ps
`default_nettype none
module cpu_status_and_power_modes
    import cpu_power_pkg::*;
#(
    parameter int MONITOR_CYCLES = cpu_power_pkg::MONITOR_TIMEOUT_CYC
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    input  wire logic [7:0]             regAddr,
    input  wire logic [7:0]             regWdata,
    input  wire logic                   instrDone,
    input  wire logic                   enabledIrq,
    input  wire logic                   watchdogEnable,
    input  wire logic                   watchdogTimeout,
    input  wire logic                   lostClockMonitorEnable,
    input  wire cpu_power_pkg::alu_op_e aluOp,
    input  wire logic                   aluCarryIn,
    input  wire logic [7:0]             aluA,
    input  wire logic [7:0]             aluB,
    input  wire logic [7:0]             accumulator,
    output logic      [7:0]             regRdata,
    output logic                        coreRun,
    output logic                        peripheralClockOn,
    output logic                        internalOscOn,
    output logic                        wakeIrqService,
    output logic                        internalReset,
    output logic      [15:0]            fetchAddress,
    output logic      [7:0]             stackPointerInit,
    output logic      [1:0]             bankSelect
);
    import cpu_power_pkg::*;

    if (MONITOR_CYCLES < 1) begin : gBadMonitor
        $error("MONITOR_CYCLES must be at least one");
    end

    power_state_e state_q, state_d;
    logic [1:0]  pwrCtl_q, pwrCtl_d;
    logic        armIdle_q, armIdle_d;
    logic        armStop_q, armStop_d;
    logic [31:0] monCnt_q, monCnt_d;
    logic        rstReq_q, rstReq_d;
    logic        wake_q, wake_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [7:0]  statusWord;
    logic [1:0]  bankSel;
    logic        pwrWr;
    logic        swWriteStatus;

    assign pwrWr         = regWrite && regAddr == POWER_MODE_CONTROL_ADDR;
    assign swWriteStatus = regWrite && regAddr == CPU_STATUS_FLAGS_ADDR;

    status_flag_unit u_flags (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .swWrite     (swWriteStatus),
        .swData      (regWdata),
        .aluOp       (aluOp),
        .aluCarryIn  (aluCarryIn),
        .aluA        (aluA),
        .aluB        (aluB),
        .accumulator (accumulator),
        .statusWord  (statusWord),
        .bankSelect  (bankSel)
    );

    always_comb begin
        state_d   = state_q;
        pwrCtl_d  = pwrCtl_q;
        armIdle_d = armIdle_q;
        armStop_d = armStop_q;
        monCnt_d  = monCnt_q;
        rstReq_d  = 1'b0;
        wake_d    = 1'b0;
        rdata_d   = rdata_q;
        // reserved bits are dropped; software is expected to write zero
        if (pwrWr) begin
            pwrCtl_d  = regWdata[1:0];
            armIdle_d = regWdata[IDLE_BIT];
            armStop_d = regWdata[STOP_BIT];
        end
        case (state_q)
            PM_RUN: begin
                monCnt_d = 32'd0;
                // entry waits for the writing instruction to finish
                if (instrDone && armStop_d) begin
                    state_d   = PM_STOP;
                    armStop_d = 1'b0;
                    armIdle_d = 1'b0;
                end else if (instrDone && armIdle_d) begin
                    state_d   = PM_IDLE;
                    armIdle_d = 1'b0;
                end
            end
            PM_IDLE: begin
                if (watchdogEnable && watchdogTimeout) begin
                    rstReq_d = 1'b1;
                end else if (enabledIrq) begin
                    state_d  = PM_RUN;
                    pwrCtl_d[IDLE_BIT] = 1'b0;
                    wake_d   = 1'b1;
                end
            end
            PM_STOP: begin
                // interrupts deliberately ignored here
                if (lostClockMonitorEnable) begin
                    // counter parks at MONITOR_CYCLES so the request stays a single pulse
                    if (monCnt_q == 32'(MONITOR_CYCLES - 1)) begin
                        rstReq_d = 1'b1;
                        monCnt_d = monCnt_q + 32'd1;
                    end else if (monCnt_q < 32'(MONITOR_CYCLES - 1)) begin
                        monCnt_d = monCnt_q + 32'd1;
                    end
                end
            end
            default: begin
                state_d = PM_RUN;
            end
        endcase
        if (regRead) begin
            case (regAddr)
                POWER_MODE_CONTROL_ADDR: rdata_d = {6'h00, pwrCtl_q};
                CPU_STATUS_FLAGS_ADDR:   rdata_d = statusWord;
                default:                 rdata_d = 8'h00;
            endcase
        end
    end

    // internal reset pulses back through the system reset tree; one cycle suffices
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= PM_RUN;
            pwrCtl_q  <= POWER_MODE_CONTROL_RST[1:0];
            armIdle_q <= 1'b0;
            armStop_q <= 1'b0;
            monCnt_q  <= 32'd0;
            rstReq_q  <= 1'b0;
            wake_q    <= 1'b0;
            rdata_q   <= 8'h00;
        end else begin
            state_q   <= state_d;
            pwrCtl_q  <= pwrCtl_d;
            armIdle_q <= armIdle_d;
            armStop_q <= armStop_d;
            monCnt_q  <= monCnt_d;
            rstReq_q  <= rstReq_d;
            wake_q    <= wake_d;
            rdata_q   <= rdata_d;
        end
    end

    logic       run_q, perClk_q, osc_q;
    logic [15:0] fetch_q;
    logic [7:0]  sp_q;
    logic [1:0]  bank_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_q    <= 1'b1;
            perClk_q <= 1'b1;
            osc_q    <= 1'b1;
            fetch_q  <= RESET_VECTOR;
            sp_q     <= STACK_POINTER_RST;
            bank_q   <= 2'b00;
        end else begin
            run_q    <= (state_d == PM_RUN);
            perClk_q <= (state_d != PM_STOP);
            osc_q    <= (state_d != PM_STOP);
            fetch_q  <= RESET_VECTOR;
            sp_q     <= STACK_POINTER_RST;
            bank_q   <= bankSel;
        end
    end

    assign coreRun           = run_q;
    assign peripheralClockOn = perClk_q;
    assign internalOscOn     = osc_q;
    assign wakeIrqService    = wake_q;
    assign internalReset     = rstReq_q;
    assign fetchAddress      = fetch_q;
    assign stackPointerInit  = sp_q;
    assign bankSelect        = bank_q;
    assign regRdata          = rdata_q;

    idle_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_RUN && instrDone && armIdle_d && !armStop_d |=> state_q == PM_IDLE && !coreRun)
        else $error("idle not entered after writing instruction");
    stop_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_RUN && instrDone && armStop_d |=> state_q == PM_STOP ##1 !internalOscOn)
        else $error("stop not entered after writing instruction");
    idle_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_IDLE && enabledIrq && !(watchdogEnable && watchdogTimeout)
        |=> wakeIrqService && !pwrCtl_q[IDLE_BIT] && state_q == PM_RUN)
        else $error("interrupt did not wake idle");
    idle_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_IDLE && !enabledIrq |=> state_q == PM_IDLE)
        else $error("idle left without cause");
    stop_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_STOP |=> state_q == PM_STOP)
        else $error("stop left without reset");
    idle_periph_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_IDLE ##1 state_q == PM_IDLE |-> peripheralClockOn && !coreRun)
        else $error("idle clocks wrong");
    wdog_reset_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == PM_IDLE && watchdogEnable && watchdogTimeout |=> internalReset)
        else $error("watchdog did not reset idle");
    monitor_time_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(internalReset) && state_q == PM_STOP |-> monCnt_q == 32'(MONITOR_CYCLES))
        else $error("monitor reset at wrong count");

    cover_idle_wake_c: cover property (@(posedge clk_sys) disable iff (!rst_n) wakeIrqService);
    cover_stop_c: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == PM_STOP);
    cover_mon_c: cover property (@(posedge clk_sys) disable iff (!rst_n) internalReset && state_q == PM_STOP);
endmodule
`default_nettype wire

// ### shared/cpu_power_pkg.sv
// Purpose: constants for the core status word and power-mode control
// Assumes: 8-bit special-register space reached by the core's own write/read port
// Notes:   offsets are special-register addresses
package cpu_power_pkg;
    localparam logic [7:0] POWER_MODE_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] CPU_STATUS_FLAGS_ADDR   = 8'hd0;
    localparam logic [7:0] POWER_MODE_CONTROL_RST  = 8'h00;
    localparam logic [7:0] CPU_STATUS_FLAGS_RST    = 8'h00;
    localparam logic [7:0] STACK_POINTER_RST       = 8'h07;
    localparam logic [15:0] RESET_VECTOR           = 16'h0000;
    localparam int IDLE_BIT         = 0;
    localparam int STOP_BIT         = 1;
    localparam int CARRY_BIT        = 7;
    localparam int HALF_CARRY_BIT   = 6;
    localparam int USER0_BIT        = 5;
    localparam int BANK_HIGH_BIT    = 4;
    localparam int BANK_LOW_BIT     = 3;
    localparam int OVERFLOW_BIT     = 2;
    localparam int USER1_BIT        = 1;
    localparam int PARITY_BIT       = 0;
    localparam logic [7:0] STATUS_WRITABLE_MASK = 8'hfe;
    localparam int CLK_HZ           = 10_000_000;
    localparam int MONITOR_TIMEOUT_US = 100;
    localparam int MONITOR_TIMEOUT_CYC = (MONITOR_TIMEOUT_US * (CLK_HZ / 1_000_000));
    typedef enum logic [1:0] {
        PM_RUN  = 2'b00,
        PM_IDLE = 2'b01,
        PM_STOP = 2'b10
    } power_state_e;
    typedef enum logic [2:0] {
        ALU_NONE = 3'b000,
        ALU_ADD  = 3'b001,
        ALU_SUBB = 3'b010,
        ALU_MUL  = 3'b011,
        ALU_DIV  = 3'b100
    } alu_op_e;
endpackage

// ### core/status_flag_unit.sv
// Purpose: status word flags, arithmetic flag updates and bank selection
// Assumes: alu operands and op valid for one cycle per executed arithmetic instruction
// Notes:   parity is computed live from the accumulator
`timescale 1ns/1ps
`default_nettype none
module status_flag_unit
    import cpu_power_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 swWrite,
    input  wire logic [7:0]           swData,
    input  wire cpu_power_pkg::alu_op_e aluOp,
    input  wire logic                 aluCarryIn,
    input  wire logic [7:0]           aluA,
    input  wire logic [7:0]           aluB,
    input  wire logic [7:0]           accumulator,
    output logic      [7:0]           statusWord,
    output logic      [1:0]           bankSelect
);
    import cpu_power_pkg::*;

    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [15:0] prod;

    always_comb begin
        flags_d = flags_q;
        sum9    = 9'h000;
        sum5    = 5'h00;
        prod    = 16'h0000;
        if (swWrite) begin
            flags_d = swData & STATUS_WRITABLE_MASK;
        end
        case (aluOp)
            ALU_ADD: begin
                sum9 = {1'b0, aluA} + {1'b0, aluB} + {8'h00, aluCarryIn};
                sum5 = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, aluCarryIn};
                flags_d[CARRY_BIT]      = sum9[8];
                flags_d[HALF_CARRY_BIT] = sum5[4];
                flags_d[OVERFLOW_BIT]   = (aluA[7] == aluB[7]) && (sum9[7] != aluA[7]);
            end
            ALU_SUBB: begin
                sum9 = {1'b0, aluA} - {1'b0, aluB} - {8'h00, aluCarryIn};
                sum5 = {1'b0, aluA[3:0]} - {1'b0, aluB[3:0]} - {4'h0, aluCarryIn};
                flags_d[CARRY_BIT]      = sum9[8];
                flags_d[HALF_CARRY_BIT] = sum5[4];
                flags_d[OVERFLOW_BIT]   = (aluA[7] != aluB[7]) && (sum9[7] != aluA[7]);
            end
            ALU_MUL: begin
                prod = aluA * aluB;
                flags_d[CARRY_BIT]    = 1'b0;
                flags_d[OVERFLOW_BIT] = (prod[15:8] != 8'h00);
            end
            ALU_DIV: begin
                flags_d[CARRY_BIT]    = 1'b0;
                flags_d[OVERFLOW_BIT] = (aluB == 8'h00);
            end
            default: begin
            end
        endcase
        flags_d[PARITY_BIT] = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= CPU_STATUS_FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // parity is read-only, never stored
    assign statusWord = {flags_q[7:1], ^accumulator};
    assign bankSelect = {flags_q[BANK_HIGH_BIT], flags_q[BANK_LOW_BIT]};

    parity_odd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        statusWord[PARITY_BIT] == ^accumulator)
        else $error("parity flag disagrees with accumulator");
    ov_div_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        aluOp == ALU_DIV && !swWrite |=> flags_q[OVERFLOW_BIT] == ($past(aluB) == 8'h00))
        else $error("overflow wrong after divide");
    ov_mul_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        aluOp == ALU_MUL |=> flags_q[OVERFLOW_BIT] == (($past(aluA) * $past(aluB)) > 255))
        else $error("overflow wrong after multiply");
endmodule
`default_nettype wire

// ### test/cpu_status_and_power_modes_tb.sv
// Purpose: self-checking bench for power modes and the status word
// Assumes: monitor count shortened to MON; internalReset is fed back to rst_n by hand
// Notes:   inputs driven by NBA at rising edges, outputs sampled 1 ns later
`timescale 1ns/1ps
`default_nettype none
module cpu_status_and_power_modes_tb;
    import cpu_power_pkg::*;
    localparam int MON = 8;
    typedef struct {alu_op_e op; logic [7:0] a; logic [7:0] b; logic [7:0] pre; logic [7:0] msk; logic [7:0] ex;} row_s;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    logic            regWrite = 1'b0;
    logic            regRead = 1'b0;
    logic [7:0]      regAddr = 8'h00;
    logic [7:0]      regWdata = 8'h00;
    logic            instrDone = 1'b0;
    logic            enabledIrq = 1'b0;
    logic            watchdogEnable = 1'b0;
    logic            watchdogTimeout = 1'b0;
    logic            lostClockMonitorEnable = 1'b0;
    alu_op_e         aluOp = ALU_NONE;
    logic            aluCarryIn = 1'b0;
    logic [7:0]      aluA = 8'h00;
    logic [7:0]      aluB = 8'h00;
    logic [7:0]      accumulator = 8'h00;
    logic [7:0]      regRdata;
    logic            coreRun;
    logic            peripheralClockOn;
    logic            internalOscOn;
    logic            wakeIrqService;
    logic            internalReset;
    logic [15:0]     fetchAddress;
    logic [7:0]      stackPointerInit;
    logic [1:0]      bankSelect;
    int              badCount = 0;
    int              checksDone = 0;
    row_s            rows [8];
    int              n;

    always #50 clk_sys = ~clk_sys;

    cpu_status_and_power_modes #(.MONITOR_CYCLES(MON)) u_cpu_status_and_power_modes (
        .clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .instrDone(instrDone), .enabledIrq(enabledIrq), .watchdogEnable(watchdogEnable),
        .watchdogTimeout(watchdogTimeout), .lostClockMonitorEnable(lostClockMonitorEnable), .aluOp(aluOp),
        .aluCarryIn(aluCarryIn), .aluA(aluA), .aluB(aluB), .accumulator(accumulator), .regRdata(regRdata),
        .coreRun(coreRun), .peripheralClockOn(peripheralClockOn), .internalOscOn(internalOscOn),
        .wakeIrqService(wakeIrqService), .internalReset(internalReset), .fetchAddress(fetchAddress),
        .stackPointerInit(stackPointerInit), .bankSelect(bankSelect));

    task automatic stopTest();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic done);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        instrDone <= done;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        instrDone <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk({8'h00, regRdata}, {8'h00, exp}, what);
    endtask

    task automatic doReset(input int k);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (k) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
    endtask

    // run state checked as three bits: run, periph clock, osc
    task automatic chkRun(input logic [2:0] exp, input string what);
        chk({13'h0, coreRun, peripheralClockOn, internalOscOn}, {13'h0, exp}, what);
    endtask

    // hang guard sized well above the fewer than two hundred cycles the tests need
    initial begin
        #(5000 * 100);
        badCount++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        stopTest();
    end

    initial begin
        rows[0] = '{ALU_ADD, 8'h7f, 8'h01, 8'h00, 8'hff, 8'h44};
        rows[1] = '{ALU_ADD, 8'hff, 8'h01, 8'h04, 8'hff, 8'hc0};
        rows[2] = '{ALU_SUBB, 8'h80, 8'h01, 8'h00, 8'hff, 8'h44};
        rows[3] = '{ALU_SUBB, 8'h00, 8'h01, 8'h04, 8'hff, 8'hc0};
        rows[4] = '{ALU_MUL, 8'h10, 8'h10, 8'h00, 8'h04, 8'h04};
        rows[5] = '{ALU_MUL, 8'h02, 8'h03, 8'h04, 8'h04, 8'h00};
        rows[6] = '{ALU_DIV, 8'h05, 8'h00, 8'h00, 8'h04, 8'h04};
        rows[7] = '{ALU_DIV, 8'h06, 8'h02, 8'h04, 8'h04, 8'h00};
        doReset(20);
        chk(fetchAddress, 16'h0000, "reset vector");
        chk({8'h00, stackPointerInit}, 16'h0007, "stack init");
        rdchk(8'h87, 8'h00, "power reset");
        rdchk(8'hd0, 8'h00, "status reset");
        wr(8'h87, 8'hfc, 1'b0);
        rdchk(8'h87, 8'h00, "reserved power bits");
        $display("test reset done");

        for (int i = 0; i < 4; i++) begin
            wr(8'hd0, {3'h0, i[1:0], 3'h0}, 1'b0);
            tick(1);
            chk({14'h0, bankSelect}, {14'h0, i[1:0]}, "bank select");
        end
        wr(8'hd0, 8'hff, 1'b0);
        rdchk(8'hd0, 8'hfe, "parity not writable");
        @(posedge clk_sys);
        accumulator <= 8'h07;
        rdchk(8'hd0, 8'hff, "parity odd");
        @(posedge clk_sys);
        accumulator <= 8'h00;
        $display("test status done");

        foreach (rows[i]) begin
            wr(8'hd0, rows[i].pre, 1'b0);
            @(posedge clk_sys);
            aluOp <= rows[i].op;
            aluA <= rows[i].a;
            aluB <= rows[i].b;
            @(posedge clk_sys);
            aluOp <= ALU_NONE;
            rd(8'hd0);
            chk({8'h00, regRdata & rows[i].msk}, {8'h00, rows[i].ex}, "arith flags");
        end
        wr(8'hd0, 8'h00, 1'b0);
        @(posedge clk_sys);
        aluOp <= ALU_ADD;
        aluA <= 8'h0f;
        aluB <= 8'h70;
        aluCarryIn <= 1'b1;
        @(posedge clk_sys);
        aluOp <= ALU_NONE;
        aluCarryIn <= 1'b0;
        rdchk(8'hd0, 8'h44, "add with carry in");
        $display("test arith done");

        wr(8'hd0, 8'h18, 1'b0);
        wr(8'h87, 8'h01, 1'b1);
        tick(2);
        chkRun(3'b011, "idle entry");
        tick(MON + 4);
        chkRun(3'b011, "idle holds");
        @(posedge clk_sys);
        enabledIrq <= 1'b1;
        tick(1);
        chk({15'h0, wakeIrqService}, 16'h0001, "irq wake pulse");
        @(posedge clk_sys);
        enabledIrq <= 1'b0;
        tick(1);
        chkRun(3'b111, "resumed");
        chk({15'h0, wakeIrqService}, 16'h0000, "wake pulse one cycle");
        rdchk(8'h87, 8'h00, "idle bit cleared");
        rdchk(8'hd0, 8'h18, "status kept over idle");
        $display("test idle irq done");

        wr(8'h87, 8'h01, 1'b1);
        tick(2);
        @(posedge clk_sys);
        watchdogEnable <= 1'b1;
        watchdogTimeout <= 1'b1;
        @(posedge clk_sys);
        watchdogTimeout <= 1'b0;
        #1;
        chk({15'h0, internalReset}, 16'h0001, "watchdog reset in idle");
        watchdogEnable <= 1'b0;
        doReset(2);
        chkRun(3'b111, "run after reset");
        chk(fetchAddress, 16'h0000, "fetch from zero");
        rdchk(8'h87, 8'h00, "power after reset");
        $display("test idle reset done");

        wr(8'h87, 8'h03, 1'b1);
        tick(2);
        chkRun(3'b000, "stop entry");
        @(posedge clk_sys);
        enabledIrq <= 1'b1;
        repeat (MON + 4) begin
            tick(1);
            chk({14'h0, wakeIrqService, internalReset}, 16'h0000, "no wake in stop");
        end
        chkRun(3'b000, "still stopped");
        @(posedge clk_sys);
        enabledIrq <= 1'b0;
        lostClockMonitorEnable <= 1'b1;
        n = 0;
        while (internalReset !== 1'b1 && n < MON + 20) begin
            tick(1);
            n++;
        end
        chk(16'(n), 16'(MON), "monitor reset timing");
        tick(1);
        chk({15'h0, internalReset}, 16'h0000, "monitor pulse one cycle");
        @(posedge clk_sys);
        lostClockMonitorEnable <= 1'b0;
        doReset(2);
        chkRun(3'b111, "run after stop reset");
        rdchk(8'h87, 8'h00, "stop bit cleared by reset");
        $display("test stop done");
        stopTest();
    end
endmodule
`default_nettype wire
